// [testbench.sv]
// Register-level testbench of the line status and modem control block
`timescale 1ns/1ns
`include "ul_consts.svh"
module testbench;
  logic        mclk = 1'h0;
  logic        srst = 1'h1;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic        awvalid = 1'h0;
  logic        wvalid = 1'h0;
  logic        bready = 1'h0;
  logic        arvalid = 1'h0;
  logic        rready = 1'h0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic [31:0] got;
  logic [1:0]  bresp;
  logic [1:0]  rresp;
  logic [1:0]  resp;
  logic        awready, wready, bvalid, arready, rvalid;
  logic        rxd, cts_n, txd, rts_n, tx_int, tx_dma_req;
  int          n_mismatch = 0;
  int          checks_done = 0;
  int          cyc = 0;
  // Pins are checked after they settle, so they are looked up by index at compare time
  wire  [3:0]  pins = {txd, rts_n, tx_int, tx_dma_req};
  localparam int PIN_DMA = 0;
  localparam int PIN_INT = 1;
  localparam int PIN_RTS = 2;
  localparam int PIN_TXD = 3;
  ul_line_status_modem dut (.mclk(mclk), .srst(srst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .rxd(rxd), .cts_n(cts_n),
    .txd(txd), .rts_n(rts_n), .tx_int(tx_int), .tx_dma_req(tx_dma_req));
  ul_far_uart far (.mclk(mclk), .txd(txd), .rxd(rxd), .cts_n(cts_n));
  always #20 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_mismatch++;
      finish_test();
    end
  end
  task automatic finish_test();
    if (n_mismatch == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error at %0t: value %h, expected %h", $time, g, e);
    end
  endtask
  // Registered pins settle a cycle after the register write lands
  task automatic chk_pin(input int b, input logic e);
    repeat (2) @(negedge mclk);
    checks_done++;
    if (pins[b] !== e) begin
      n_mismatch++;
      $display("Error at %0t: pin %0d is %b, expected %b", $time, b, pins[b], e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge mclk);
      if (awready === 1'h1) awvalid <= 1'h0;
      if (wready === 1'h1) wvalid <= 1'h0;
    end while (bvalid !== 1'h1);
    resp = bresp;
    bready <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge mclk);
      if (arready === 1'h1) arvalid <= 1'h0;
    end while (rvalid !== 1'h1);
    got = rdata;
    resp = rresp;
    rready <= 1'h0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    rd(a);
    chk(got & m, e);
  endtask
  task automatic rx_char(input logic [7:0] d, input logic pen, input logic par, input logic stp);
    far.send(d, pen, par, stp);
    repeat (8) @(posedge mclk);
  endtask
  initial begin
    repeat (4) @(posedge mclk);
    srst <= 1'h0;
    @(posedge mclk);
    rc(`UL_OFF_LSR, 32'hff, 32'h60);
    wr(`UL_OFF_MCR, 32'hff);
    rc(`UL_OFF_MCR, 32'hff, 32'h92);
    rc(`UL_OFF_MSR, 32'h10, 32'h10);
    chk_pin(PIN_RTS, 1'h1);
    wr(`UL_OFF_MCR, 32'h82);
    chk_pin(PIN_RTS, 1'h0);
    far.set_cts(1'h0);
    rc(`UL_OFF_MSR, 32'h10, 32'h10);
    wr(`UL_OFF_MCR, 32'h02);
    rc(`UL_OFF_MSR, 32'h10, 32'h00);
    wr(`UL_OFF_MCR, 32'h80);
    chk_pin(PIN_RTS, 1'h1);
    far.set_cts(1'h1);
    rc(`UL_OFF_MSR, 32'h10, 32'h00);
    wr(`UL_OFF_MCR, 32'h00);
    wr(`UL_OFF_LSR, 32'hff);
    chk({30'h0, resp}, 32'h2);
    rd(8'h40);
    chk({30'h0, resp}, 32'h2);
    wr(`UL_OFF_DIV, 32'h4);
    wr(`UL_OFF_FCR, 32'h10);
    rx_char(8'h5a, 1'h0, 1'h0, 1'h1);
    rc(`UL_OFF_LSR, 32'hff, 32'h61);
    rc(`UL_OFF_DATA, 32'hff, 32'h5a);
    rc(`UL_OFF_LSR, 32'h01, 32'h00);
    wr(`UL_OFF_LCR, 32'h1b);
    rx_char(8'h5a, 1'h1, 1'h1, 1'h1);
    rc(`UL_OFF_LSR, 32'h8f, 32'h05);
    rc(`UL_OFF_LSR, 32'h04, 32'h00);
    rd(`UL_OFF_DATA);
    wr(`UL_OFF_LCR, 32'h03);
    rx_char(8'h33, 1'h0, 1'h0, 1'h0);
    rc(`UL_OFF_LSR, 32'h0f, 32'h09);
    rd(`UL_OFF_DATA);
    far.brk(12);
    rc(`UL_OFF_LSR, 32'h10, 32'h10);
    rc(`UL_OFF_LSR, 32'h10, 32'h00);
    rd(`UL_OFF_DATA);
    for (int i = 0; i < 3; i++) rx_char(8'h44, 1'h0, 1'h0, 1'h1);
    rc(`UL_OFF_LSR, 32'h03, 32'h03);
    rc(`UL_OFF_LSR, 32'h02, 32'h00);
    wr(`UL_OFF_FCR, 32'h12);
    rc(`UL_OFF_LSR, 32'h01, 32'h00);
    wr(`UL_OFF_FCR, 32'h13);
    rx_char(8'h11, 1'h0, 1'h0, 1'h1);
    rx_char(8'h22, 1'h0, 1'h0, 1'h0);
    rc(`UL_OFF_LSR, 32'h8f, 32'h81);
    rc(`UL_OFF_DATA, 32'hff, 32'h11);
    rc(`UL_OFF_LSR, 32'h8f, 32'h89);
    rc(`UL_OFF_DATA, 32'hff, 32'h22);
    rc(`UL_OFF_LSR, 32'h81, 32'h00);
    far.brk(40);
    rc(`UL_OFF_LSR, 32'h11, 32'h11);
    rc(`UL_OFF_DATA, 32'hff, 32'h00);
    rc(`UL_OFF_LSR, 32'h01, 32'h00);
    // Twelve quick writes outrun the shifter, leaving more than half the holding store full
    for (int i = 0; i < 12; i++) wr(`UL_OFF_DATA, 32'h30 + i);
    rc(`UL_OFF_LSR, 32'h60, 32'h00);
    for (int k = 0; k < 2000 && far.n_rx < 12; k++) @(posedge mclk);
    chk(far.n_rx, 12);
    chk({24'h0, far.last}, 32'h3b);
    rc(`UL_OFF_LSR, 32'h60, 32'h60);
    wr(`UL_OFF_IER, 32'h02);
    chk_pin(PIN_INT, 1'h1);
    wr(`UL_OFF_IER, 32'h00);
    chk_pin(PIN_INT, 1'h0);
    wr(`UL_OFF_FCR, 32'h19);
    chk_pin(PIN_DMA, 1'h1);
    wr(`UL_OFF_IER, 32'h02);
    chk_pin(PIN_DMA, 1'h0);
    wr(`UL_OFF_IER, 32'h00);
    wr(`UL_OFF_FCR, 32'h00);
    wr(`UL_OFF_MCR, 32'h10);
    wr(`UL_OFF_FCR, 32'h10);
    wr(`UL_OFF_DATA, 32'ha5);
    for (int k = 0; k < 100 && got[0] !== 1'h1; k++) rd(`UL_OFF_LSR);
    chk(far.n_rx, 12);
    chk_pin(PIN_TXD, 1'h1);
    rc(`UL_OFF_DATA, 32'hff, 32'ha5);
    wr(`UL_OFF_MCR, 32'h00);
    finish_test();
  end
endmodule

// [ul_consts.svh]
// Register offsets, field positions, reset values and sizes of the line status and modem control block
`ifndef UL_CONSTS_SVH
`define UL_CONSTS_SVH
`define UL_OFF_DATA     8'h00
`define UL_OFF_IER      8'h04
`define UL_OFF_FCR      8'h08
`define UL_OFF_LCR      8'h0c
`define UL_OFF_MCR      8'h10
`define UL_OFF_LSR      8'h14
`define UL_OFF_MSR      8'h18
`define UL_OFF_DIV      8'h1c
`define UL_IER_TX_REQ_INT_ENABLE    1
`define UL_FCR_FME      0
`define UL_FCR_RX_FIFO_RESET     1
`define UL_FCR_TFRT     2
`define UL_FCR_DME      3
`define UL_FCR_UME      4
`define UL_LCR_SBLS     2
`define UL_LCR_PARE     3
`define UL_LCR_PARM     4
`define UL_LCR_STPAR    5
`define UL_MCR_RTS      1
`define UL_MCR_LOOP     4
`define UL_MCR_MODEM_CTRL_ENABLE     7
`define UL_MCR_MASK     8'h92
`define UL_MSR_CTS      4
`define UL_IER_RST      8'h00
`define UL_LCR_RST      8'h03
`define UL_MCR_RST      8'h00
`define UL_DIV_RST      16'h00d9
`define UL_DEPTH        16
`define UL_DEPTH_W      5'h10
`define UL_TX_DATA_REQUEST_LEVEL   5'h08
`define UL_RESP_OKAY    2'h0
`define UL_RESP_SLVERR  2'h2
`endif

// [ul_far_uart.sv]
// Far-side serial partner: sends frames on the receive pin and captures the transmit pin
`timescale 1ns/1ns
module ul_far_uart (
  input  wire logic mclk,
  input  wire logic txd,
  output logic      rxd,
  output logic      cts_n
);
  int         div = 4;
  int         n_rx = 0;
  logic [7:0] last;
  initial begin
    rxd = 1'h1;
    cts_n = 1'h1;
  end
  task automatic bit_out(input logic v);
    @(posedge mclk);
    rxd <= v;
    repeat (div - 1) @(posedge mclk);
  endtask
  // LSB first, one idle bit after the stop so frames never merge
  task automatic send(input logic [7:0] d, input logic pen, input logic par, input logic stp);
    bit_out(1'h0);
    for (int i = 0; i < 8; i++) bit_out(d[i]);
    if (pen) bit_out(par);
    bit_out(stp);
    bit_out(1'h1);
  endtask
  task automatic brk(input int n);
    bit_out(1'h0);
    repeat (n * div) @(posedge mclk);
    bit_out(1'h1);
  endtask
  // Handshake line changes on a rising edge; the wait covers the pin synchroniser
  task automatic set_cts(input logic v);
    @(posedge mclk);
    cts_n <= v;
    repeat (6) @(posedge mclk);
  endtask
  // Samples mid-bit; assumes 8 data bits and no parity on the transmit side
  initial forever begin
    @(negedge txd);
    repeat (div + div / 2) @(posedge mclk);
    for (int i = 0; i < 8; i++) begin
      last[i] = txd;
      repeat (div) @(posedge mclk);
    end
    n_rx++;
  end
endmodule

// [ul_line_status_modem.sv]
// UART core with line status, modem control, loopback and an AXI4-Lite register slave
`timescale 1ns/1ns
`include "ul_consts.svh"
module ul_line_status_modem (
  input  wire logic        mclk,
  input  wire logic        srst,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        rxd,
  input  wire logic        cts_n,
  output logic             txd,
  output logic             rts_n,
  output logic             tx_int,
  output logic             tx_dma_req
);
  logic [7:0]  int_enable_reg;
  logic [7:0]  line_ctrl;
  logic [7:0]  modem_control_reg;
  logic        fme;
  logic        dme;
  logic        ume;
  logic [15:0] div;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic [2:0]  rx_sync;
  logic [2:0]  cts_sync;
  logic        rx_pin;
  logic        cts_pin;

  // Pin inputs: a change counts once the last two stages agree
  always_ff @(posedge mclk) begin
    if (srst) begin
      rx_sync  <= 3'h7;
      cts_sync <= 3'h7;
      rx_pin   <= 1'b1;
      cts_pin  <= 1'b1;
    end else begin
      rx_sync  <= {rx_sync[1:0], rxd};
      cts_sync <= {cts_sync[1:0], cts_n};
      if (rx_sync[1] == rx_sync[2]) begin
        rx_pin <= rx_sync[2];
      end
      if (cts_sync[1] == cts_sync[2]) begin
        cts_pin <= cts_sync[2];
      end
    end
  end

  wire       loop     = modem_control_reg[`UL_MCR_LOOP];
  wire       modem_ctrl_enable     = modem_control_reg[`UL_MCR_MODEM_CTRL_ENABLE];
  wire       rts_bit  = modem_control_reg[`UL_MCR_RTS];
  wire       tx_req_int_enable    = int_enable_reg[`UL_IER_TX_REQ_INT_ENABLE];
  wire       pare     = line_ctrl[`UL_LCR_PARE];
  wire       parm     = line_ctrl[`UL_LCR_PARM];
  wire       stpar    = line_ctrl[`UL_LCR_STPAR];
  wire [3:0] nbits    = 4'h5 + {2'h0, line_ctrl[1:0]};
  wire [4:0] lim      = fme ? `UL_DEPTH_W : 5'h01;
  // Clear status follows the request bit in loopback, else the pin only while enabled
  wire       cts_stat = loop ? rts_bit : (modem_ctrl_enable & ~cts_pin);
  // Handshake holds off new characters only while modem function is on
  wire       cts_ok   = ~modem_ctrl_enable | cts_stat;

  // Bus write: address and data taken in either order, applied once both are held
  wire wr_fire = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
  wire rd_fire = s_axi_arvalid & s_axi_arready;
  wire wr_lo   = wr_fire & w_strb[0];
  wire wr_data = wr_lo & (aw_addr == `UL_OFF_DATA);
  wire wr_fcr  = wr_lo & (aw_addr == `UL_OFF_FCR);
  wire rx_clr  = wr_fcr & w_data[`UL_FCR_RX_FIFO_RESET];
  wire tx_clr  = wr_fcr & w_data[`UL_FCR_TFRT];
  wire rd_data = rd_fire & (s_axi_araddr == `UL_OFF_DATA);
  wire lsr_rd  = rd_fire & (s_axi_araddr == `UL_OFF_LSR);
  wire wr_hit  = (aw_addr[1:0] == 2'h0) && (aw_addr <= `UL_OFF_DIV) && (aw_addr != `UL_OFF_LSR)
                 && (aw_addr != `UL_OFF_MSR);

  // Transmit holding storage
  logic [7:0]  tx_mem [`UL_DEPTH];
  logic [3:0]  tx_wp;
  logic [3:0]  tx_rp;
  logic [4:0]  tx_cnt;
  ul_pkg::ul_tx_state_e tx_state;
  logic [11:0] tx_shift;
  logic [3:0]  tx_left;
  logic [15:0] tx_tmr;
  logic [11:0] tx_frame;
  logic [7:0]  tx_head;

  wire tx_push  = wr_data & (tx_cnt < lim);
  wire tx_load  = ume & (tx_state == ul_pkg::UL_TX_IDLE) & (tx_cnt != 5'h00) & cts_ok;
  wire tx_tick  = (tx_state == ul_pkg::UL_TX_SHIFT) & (tx_tmr == 16'h0000);
  wire tx_line  = (tx_state == ul_pkg::UL_TX_SHIFT) ? tx_shift[0] : 1'b1;
  wire tx_pbit  = stpar ? ~parm : ((^(tx_head & ~(8'hff << nbits))) ^ ~parm);
  wire [3:0] tx_total = 4'h2 + nbits + {3'h0, pare} + {3'h0, line_ctrl[`UL_LCR_SBLS]};
  wire tx_idle  = (tx_cnt == 5'h00) & (tx_state == ul_pkg::UL_TX_IDLE);
  wire tx_data_request     = fme ? (tx_cnt <= `UL_TX_DATA_REQUEST_LEVEL) : (tx_cnt == 5'h00);

  assign tx_head = tx_mem[tx_rp];

  // Start bit, data, optional parity, then stop ones; 1.5 stop bits sent as two
  always_comb begin
    tx_frame = 12'hfff;
    tx_frame[0] = 1'b0;
    for (int j = 1; j < 12; j++) begin
      if (4'(j - 1) < nbits) begin
        tx_frame[j] = tx_head[j - 1];
      end else if ((4'(j - 1) == nbits) && pare) begin
        tx_frame[j] = tx_pbit;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (tx_push) begin
      // Latched copy: the master may change wdata once the channel has been taken
      tx_mem[tx_wp] <= w_data[7:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (srst || tx_clr) begin
      tx_wp  <= 4'h0;
      tx_rp  <= 4'h0;
      tx_cnt <= 5'h00;
    end else begin
      tx_wp  <= tx_wp + {3'h0, tx_push};
      tx_rp  <= tx_rp + {3'h0, tx_load};
      tx_cnt <= tx_cnt + {4'h0, tx_push} - {4'h0, tx_load};
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      tx_state <= ul_pkg::UL_TX_IDLE;
      tx_shift <= 12'hfff;
      tx_left  <= 4'h0;
      tx_tmr   <= 16'h0000;
    end else if (tx_load) begin
      tx_state <= ul_pkg::UL_TX_SHIFT;
      tx_shift <= tx_frame;
      tx_left  <= tx_total;
      tx_tmr   <= div - 16'h0001;
    end else if (tx_tick) begin
      tx_shift <= {1'b1, tx_shift[11:1]};
      tx_left  <= tx_left - 4'h1;
      tx_tmr   <= div - 16'h0001;
      if (tx_left == 4'h1) begin
        tx_state <= ul_pkg::UL_TX_IDLE;
      end
    end else if (tx_state == ul_pkg::UL_TX_SHIFT) begin
      tx_tmr <= tx_tmr - 16'h0001;
    end
  end

  // Receiver, sampling mid-bit
  ul_pkg::ul_rx_state_e rx_state;
  logic [11:0] rx_bits;
  logic [3:0]  rx_idx;
  logic [15:0] rx_tmr;
  logic [7:0]  rx_dat;
  ul_pkg::ul_rx_entry_t rx_new;
  ul_pkg::ul_rx_entry_t rx_hold;
  logic        rx_hold_v;
  logic        ovr;

  wire       rx_in    = loop ? tx_line : rx_pin;
  wire [3:0] rx_total = 4'h2 + nbits + {3'h0, pare};
  wire       rx_tick  = (rx_state == ul_pkg::UL_RX_BUSY) & (rx_tmr == 16'h0000);
  wire       rx_done  = rx_tick & (rx_idx == rx_total - 4'h1);
  wire [3:0] pidx     = nbits + 4'h1;
  wire       rx_pbit  = rx_bits[pidx];
  // Whole character low, stop included, is a break
  wire       rx_brk   = ~rx_in & (rx_bits == 12'h000);
  wire       rx_frm   = ~rx_in;
  wire       rx_par   = pare & (stpar ? (rx_pbit == parm) : ((^rx_dat ^ rx_pbit) == parm));

  always_comb begin
    rx_dat = 8'h00;
    for (int i = 0; i < 8; i++) begin
      if (4'(i) < nbits) begin
        rx_dat[i] = rx_bits[i + 1];
      end
    end
    // A break is stored as one all-zero character
    if (rx_brk) begin
      rx_new = {4'b1100, 8'h00};
    end else begin
      rx_new = {rx_frm | rx_par, 1'b0, rx_frm, rx_par, rx_dat};
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      rx_state <= ul_pkg::UL_RX_IDLE;
      rx_bits  <= 12'h000;
      rx_idx   <= 4'h0;
      rx_tmr   <= 16'h0000;
    end else begin
      unique case (rx_state)
        ul_pkg::UL_RX_IDLE: begin
          if (ume && !rx_in) begin
            rx_state <= ul_pkg::UL_RX_BUSY;
            rx_bits  <= 12'h000;
            rx_idx   <= 4'h0;
            rx_tmr   <= {1'b0, div[15:1]};
          end
        end
        ul_pkg::UL_RX_BUSY: begin
          if (rx_tick) begin
            rx_bits[rx_idx] <= rx_in;
            rx_idx <= rx_idx + 4'h1;
            rx_tmr <= div - 16'h0001;
            if (rx_idx == 4'h0 && rx_in) begin
              rx_state <= ul_pkg::UL_RX_IDLE;
            end else if (rx_done) begin
              // Wait for the line to rise so a long break yields one character
              rx_state <= rx_brk ? ul_pkg::UL_RX_BRKWAIT : ul_pkg::UL_RX_IDLE;
            end
          end else begin
            rx_tmr <= rx_tmr - 16'h0001;
          end
        end
        ul_pkg::UL_RX_BRKWAIT: begin
          if (rx_in) begin
            rx_state <= ul_pkg::UL_RX_IDLE;
          end
        end
        default: begin
          rx_state <= ul_pkg::UL_RX_IDLE;
        end
      endcase
    end
  end

  // Receive buffer: finished characters wait in the hold register until there is room
  ul_pkg::ul_rx_entry_t rx_mem [`UL_DEPTH];
  logic [3:0] rx_wp;
  logic [3:0] rx_rp;
  logic [4:0] rx_cnt;
  logic [4:0] err_cnt;

  wire rx_hv     = rx_cnt != 5'h00;
  wire hold_move = rx_hold_v & (rx_cnt < lim);
  wire rx_pop    = rd_data & rx_hv;
  wire ovr_set   = rx_done & rx_hold_v & ~hold_move;
  ul_pkg::ul_rx_entry_t rx_head;
  assign rx_head = rx_mem[rx_rp];

  always_ff @(posedge mclk) begin
    // Status read clears the head flags; a push into the same slot is written after and wins
    if (lsr_rd && rx_hv) begin
      rx_mem[rx_rp][10:8] <= 3'h0;
    end
    if (hold_move) begin
      rx_mem[rx_wp] <= rx_hold;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst || rx_clr) begin
      rx_wp     <= 4'h0;
      rx_rp     <= 4'h0;
      rx_cnt    <= 5'h00;
      err_cnt   <= 5'h00;
      rx_hold_v <= 1'b0;
      rx_hold   <= 12'h000;
    end else begin
      rx_wp   <= rx_wp + {3'h0, hold_move};
      rx_rp   <= rx_rp + {3'h0, rx_pop};
      rx_cnt  <= rx_cnt + {4'h0, hold_move} - {4'h0, rx_pop};
      err_cnt <= err_cnt + {4'h0, hold_move & rx_hold[11]} - {4'h0, rx_pop & rx_head[11]};
      if (rx_done && (!rx_hold_v || hold_move)) begin
        rx_hold   <= rx_new;
        rx_hold_v <= 1'b1;
      end else if (hold_move) begin
        rx_hold_v <= 1'b0;
      end
    end
  end

  // Overrun: the new character is dropped; a set in the clearing cycle wins
  always_ff @(posedge mclk) begin
    if (srst) begin
      ovr <= 1'b0;
    end else if (ovr_set) begin
      ovr <= 1'b1;
    end else if (lsr_rd) begin
      ovr <= 1'b0;
    end
  end

  // Flags follow the head character, which is the next one software reads
  wire [7:0] line_status_reg = {fme & ((err_cnt != 5'h00) | ovr), tx_idle, tx_data_request,
                                rx_hv & rx_head[10], rx_hv & rx_head[9], rx_hv & rx_head[8],
                                ovr, rx_hv};
  wire [7:0] modem_status_reg = {3'h0, cts_stat, 4'h0};
  wire [7:0] fifo_control_reg = {3'h0, ume, dme, 2'h0, fme};

  logic [31:0] rd_val;
  logic        rd_ok;
  always_comb begin
    rd_val = 32'h0000_0000;
    rd_ok  = 1'b1;
    unique case (s_axi_araddr)
      `UL_OFF_DATA: rd_val[7:0] = rx_head[7:0];
      `UL_OFF_IER:  rd_val[7:0] = int_enable_reg;
      `UL_OFF_FCR:  rd_val[7:0] = fifo_control_reg;
      `UL_OFF_LCR:  rd_val[7:0] = line_ctrl;
      `UL_OFF_MCR:  rd_val[7:0] = modem_control_reg;
      `UL_OFF_LSR:  rd_val[7:0] = line_status_reg;
      `UL_OFF_MSR:  rd_val[7:0] = modem_status_reg;
      `UL_OFF_DIV:  rd_val[15:0] = div;
      default:      rd_ok = 1'b0;
    endcase
  end

  // Bus channel handshakes
  always_ff @(posedge mclk) begin
    if (srst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `UL_RESP_OKAY;
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `UL_RESP_OKAY;
      aw_addr       <= 8'h00;
      w_data        <= 32'h0000_0000;
      w_strb        <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        aw_addr       <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        w_data       <= s_axi_wdata;
        w_strb       <= s_axi_wstrb;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? `UL_RESP_OKAY : `UL_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
      if (rd_fire) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_val;
        s_axi_rresp   <= rd_ok ? `UL_RESP_OKAY : `UL_RESP_SLVERR;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // Control registers; loopback should be set before the enable, nothing here enforces it
  always_ff @(posedge mclk) begin
    if (srst) begin
      int_enable_reg    <= `UL_IER_RST;
      line_ctrl         <= `UL_LCR_RST;
      modem_control_reg <= `UL_MCR_RST;
      fme               <= 1'b0;
      dme               <= 1'b0;
      ume               <= 1'b0;
      div               <= `UL_DIV_RST;
    end else begin
      if (wr_lo && aw_addr == `UL_OFF_IER) begin
        int_enable_reg <= w_data[7:0] & 8'h02;
      end
      if (wr_lo && aw_addr == `UL_OFF_LCR) begin
        line_ctrl <= w_data[7:0] & 8'h3f;
      end
      if (wr_lo && aw_addr == `UL_OFF_MCR) begin
        modem_control_reg <= w_data[7:0] & `UL_MCR_MASK;
      end
      if (wr_fcr) begin
        fme <= w_data[`UL_FCR_FME];
        dme <= w_data[`UL_FCR_DME];
        ume <= w_data[`UL_FCR_UME];
      end
      if (wr_fire && aw_addr == `UL_OFF_DIV) begin
        if (w_strb[0]) begin
          div[7:0] <= w_data[7:0];
        end
        if (w_strb[1]) begin
          div[15:8] <= w_data[15:8];
        end
      end
    end
  end

  // Pins and requests
  always_ff @(posedge mclk) begin
    if (srst) begin
      txd        <= 1'b1;
      rts_n      <= 1'b1;
      tx_int     <= 1'b0;
      tx_dma_req <= 1'b0;
    end else begin
      txd        <= loop ? 1'b1 : tx_line;
      rts_n      <= loop ? 1'b1 : ~rts_bit;
      tx_int     <= tx_req_int_enable & tx_data_request;
      tx_dma_req <= dme & ~tx_req_int_enable & tx_data_request;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  sequence mcr_rts_wr;
    wr_lo && (aw_addr == `UL_OFF_MCR) && w_data[`UL_MCR_RTS] && !w_data[`UL_MCR_LOOP];
  endsequence
  sequence tx_push_seen;
    tx_push && (tx_state == ul_pkg::UL_TX_IDLE);
  endsequence

  tx_idle_push_a: assert property (tx_push_seen |=> !line_status_reg[6])
    else $error("transmitter idle with a character held");
  tx_data_request_level_a: assert property (!fme && tx_cnt != 5'h00 |-> !line_status_reg[5])
    else $error("data request set with holding register full");
  tx_int_set_a: assert property (tx_req_int_enable && tx_data_request && !tx_clr |=> tx_int)
    else $error("transmit interrupt missing");
  dma_req_cause_a: assert property (tx_dma_req |-> $past(dme) && !$past(tx_req_int_enable) && $past(tx_data_request))
    else $error("DMA request without cause");
  head_flags_clr_a: assert property (lsr_rd && rx_cnt > 5'h01 |=> line_status_reg[4:2] == 3'h0)
    else $error("head error flags survive status read");
  overrun_set_a: assert property (ovr_set |=> line_status_reg[1])
    else $error("overrun flag not set");
  rx_reset_ready_a: assert property (rx_clr |=> !line_status_reg[0])
    else $error("data ready survives receive reset");
  fifo_err_zero_a: assert property (!fme |-> !line_status_reg[7])
    else $error("FIFO error set outside FIFO mode");
  rts_pin_low_a: assert property (mcr_rts_wr |-> ##2 !rts_n)
    else $error("request pin not driven low");
  loop_txd_high_a: assert property (loop |=> txd)
    else $error("transmit pin not high in loopback");
endmodule

// [ul_pkg.sv]
// Types shared by the line status and modem control block
package ul_pkg;
  typedef enum logic {UL_TX_IDLE, UL_TX_SHIFT} ul_tx_state_e;
  typedef enum logic [1:0] {UL_RX_IDLE, UL_RX_BUSY, UL_RX_BRKWAIT} ul_rx_state_e;
  typedef logic [11:0] ul_rx_entry_t;
endpackage
